// [sdac_bus_master.sv]
/*
  bus master model: start, stop and byte writes at 200 ns per scl period.
  assumes the bench resolves the open-drain sda and feeds it back.
*/
`timescale 1ns/1ps
module sdac_bus_master (
  input  wire logic clk_sys,
  input  wire logic sdaLine,
  output logic      sclOut,
  output logic      sdaDrv
);
  // idle bus: both released high, clock stands still between frames
  initial begin
    sclOut = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wt
  // low 5 cycles, high 3; sda read late in high so slow acks show
  task automatic bit_out(input logic b, output logic s);
    sdaDrv = b;
    wt(3);
    sclOut = 1'b1;
    wt(2);
    s = sdaLine;
    wt(1);
    sclOut = 1'b0;
    wt(2);
  endtask : bit_out
  task automatic start_cond();
    sdaDrv = 1'b1;
    wt(2);
    sclOut = 1'b1;
    wt(3);
    sdaDrv = 1'b0;
    wt(3);
    sclOut = 1'b0;
    wt(2);
  endtask : start_cond
  task automatic stop_cond();
    sdaDrv = 1'b0;
    wt(3);
    sclOut = 1'b1;
    wt(3);
    sdaDrv = 1'b1;
    wt(6);
  endtask : stop_cond
  // msb first; a short count aborts mid-byte with no ack clock
  task automatic byte_out(input logic [7:0] b, input int n, output logic ack);
    logic s;
    ack = 1'b0;
    for (int i = 7; i > 7 - n; i--) begin
      bit_out(b[i], s);
    end
    if (n == 8) begin
      bit_out(1'b1, s);
      ack = !s;
    end
  endtask : byte_out
endmodule : sdac_bus_master

// [sdac_map.svh]
/*
  constants of the two-wire converter write port: addresses, command bit
  positions and reset values.
  assumes inclusion by bare name from the write port module.
*/
`ifndef SDAC_MAP_SVH
`define SDAC_MAP_SVH

// broadcast address shared by all converters on the bus
`define SDAC_SYNC_ADDR      7'h7e
// upper address nibble of the pin-strapped variants
`define SDAC_PREFIX_MAIN    4'h4
`define SDAC_PREFIX_ALT     4'h3
// fixed addresses of the small-package versions
`define SDAC_FIXED_ADDR_0   7'h20
`define SDAC_FIXED_ADDR_1   7'h21
`define SDAC_FIXED_ADDR_2   7'h22
// command byte field positions
`define SDAC_CMD_SYNC_BIT   0
`define SDAC_CMD_PDOWN_BIT  1
`define SDAC_CMD_REF_BIT    2
// power-on values
`define SDAC_CMD_RESET      8'h00
`define SDAC_DATA_RESET     8'h00
`define SDAC_CODE_RESET     10'h000
// byte positions inside a write word transaction
`define SDAC_BYTE_ADDR      2'h0
`define SDAC_BYTE_CMD       2'h1
`define SDAC_BYTE_LOW       2'h2
`define SDAC_BYTE_HIGH      2'h3
`define SDAC_LAST_BIT       3'h7

`endif

// [sdac_pin_sync.sv]
/*
  two flip-flop synchroniser for a group of pin inputs.
  assumes the inputs are quasi-static or slow against clk_sys.
*/
`timescale 1ns/1ps
module sdac_pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             rstN,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinSync
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  // idle bus level is high, so reset to ones to avoid a false start
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      stage1_ff <= {WIDTH{1'b1}};
      stage2_ff <= {WIDTH{1'b1}};
    end else begin
      stage1_ff <= pinIn;
      stage2_ff <= stage1_ff;
    end
  end

  assign pinSync = stage2_ff;

endmodule : sdac_pin_sync

// [sdac_pkg.sv]
/*
  types shared by the converter write port.
  assumes nothing beyond a SystemVerilog compiler.
*/
package sdac_pkg;

  // one-hot receive states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RECV = 4'h2,
    ST_ACK  = 4'h4,
    ST_SKIP = 4'h8
  } sdac_state_t;

endpackage : sdac_pkg

// [sdac_write_port.sv]
/*
  receive-only two-wire slave front end of a 10-bit converter: address
  decode, command and data input registers, double-buffered output code,
  power-down and reference select, broadcast update or clear.
  assumes scl and sda arrive unsynchronised from pins, that the master
  keeps standard-mode timing (scl periods far above 4 clk_sys cycles) and
  that the pad turns sdaOut/sdaOutEnN into an open-drain line.
*/
// Contract
// RULE_01 - acknowledge own address with write bit
// RULE_02 - first byte acked, stored as command
// RULE_03 - second byte acked, kept as low data
// RULE_04 - third byte acked, stored as high data
// RULE_05 - stop copies input to output registers
// RULE_06 - pin variant: prefix plus three pins
// RULE_07 - small package: one fixed address
// RULE_08 - code is high[1:0] with low byte
// RULE_09 - sync select blocks update on stop
// RULE_10 - sync update on ack rising edge
// RULE_11 - power-down keeps all latched contents
// RULE_12 - power-down change applied on stop
// RULE_13 - bit 2 selects internal reference
// RULE_14 - power-on zero, bits 7..3 ignored
// RULE_15 - send byte updates command only
// RULE_16 - interrupted data discarded, command kept
// RULE_17 - interrupted command byte discarded
// RULE_18 - answer broadcast quick command address
// RULE_19 - broadcast update only with sync select
// RULE_20 - broadcast zero bit clears everything
// RULE_21 - master chains starts, one final stop
// RULE_22 - detect start and stop conditions
// RULE_23 - ack drives sda low through ninth clock
// RULE_24 - sample on scl rise, receive only
// RULE_25 - unmatched or read: release and ignore
// RULE_26 - clear zeroes command, input, output
`timescale 1ns/1ps
`include "sdac_map.svh"
module sdac_write_port #(
  parameter bit         USE_ADDR_PINS = 1'b1,
  parameter logic [3:0] ADDR_PREFIX   = `SDAC_PREFIX_MAIN,
  parameter logic [6:0] FIXED_ADDR    = `SDAC_FIXED_ADDR_0
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  input  wire logic [2:0] addrSelPin,
  output logic            sdaOut,
  output logic            sdaOutEnN,
  output logic [9:0]      converterCode,
  output logic            powerDownSelect,
  output logic            internalRefSelect,
  output logic            syncUpdateSelect
);

  logic [1:0]            rstSync_ff;
  logic                  rstN;
  logic                  sclS;
  logic                  sdaS;
  logic [2:0]            addrSelS;
  logic                  sclPrev_ff;
  logic                  sdaPrev_ff;
  logic                  sclRise;
  logic                  sclFall;
  logic                  startDet;
  logic                  stopDet;
  sdac_pkg::sdac_state_t state_ff,    nxt_state;
  logic [2:0]            bitCnt_ff,   nxt_bitCnt;
  logic [7:0]            shift_ff,    nxt_shift;
  logic                  full_ff,     nxt_full;
  logic [1:0]            byteIdx_ff,  nxt_byteIdx;
  logic                  isSync_ff,   nxt_isSync;
  logic                  accept_ff,   nxt_accept;
  logic                  sdaOeN_ff,   nxt_sdaOeN;
  logic [7:0]            cmdIn_ff,    nxt_cmdIn;
  logic [7:0]            lowTmp_ff,   nxt_lowTmp;
  logic [7:0]            lowIn_ff,    nxt_lowIn;
  logic [7:0]            highIn_ff,   nxt_highIn;
  logic [9:0]            code_ff,     nxt_code;
  logic                  pdown_ff,    nxt_pdown;
  logic                  refSel_ff,   nxt_refSel;
  logic                  sdaDrive_ff;
  logic [7:0]            rxByte;

  // own slave address check, pins or fixed per variant
  function automatic logic addrMatch(input logic [6:0] addr, input logic [2:0] pins);
    logic [6:0] own;
    // RULE_06 prefix and pins
    own = {ADDR_PREFIX, pins};
    // RULE_07 fixed address
    if (!USE_ADDR_PINS) begin
      own = FIXED_ADDR;
    end
    addrMatch = (addr == own);
  endfunction : addrMatch

  // RULE_08 code assembly
  function automatic logic [9:0] codeOf(input logic [7:0] hi, input logic [7:0] lo);
    codeOf = {hi[1:0], lo};
  endfunction : codeOf

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_ff <= 2'h0;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
  end
  assign rstN = rstSync_ff[1];

  // bus lines and straps cross into clk_sys
  sdac_pin_sync #(
    .WIDTH (5)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .rstN    (rstN),
    .pinIn   ({sclIn, sdaIn, addrSelPin}),
    .pinSync ({sclS, sdaS, addrSelS})
  );

  // edge history, read only after the synchroniser
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      sclPrev_ff <= 1'b1;
      sdaPrev_ff <= 1'b1;
    end else begin
      sclPrev_ff <= sclS;
      sdaPrev_ff <= sdaS;
    end
  end

  // RULE_24 rising edge samples data
  assign sclRise  = sclS & ~sclPrev_ff;
  assign sclFall  = ~sclS & sclPrev_ff;
  // RULE_22 start and stop
  assign startDet = sclS & sclPrev_ff & sdaPrev_ff & ~sdaS;
  assign stopDet  = sclS & sclPrev_ff & ~sdaPrev_ff & sdaS;
  assign rxByte   = {shift_ff[6:0], sdaS};

  // protocol and register next values
  always_comb begin
    nxt_state   = state_ff;
    nxt_bitCnt  = bitCnt_ff;
    nxt_shift   = shift_ff;
    nxt_full    = full_ff;
    nxt_byteIdx = byteIdx_ff;
    nxt_isSync  = isSync_ff;
    nxt_accept  = accept_ff;
    nxt_sdaOeN  = sdaOeN_ff;
    nxt_cmdIn   = cmdIn_ff;
    nxt_lowTmp  = lowTmp_ff;
    nxt_lowIn   = lowIn_ff;
    nxt_highIn  = highIn_ff;
    nxt_code    = code_ff;
    nxt_pdown   = pdown_ff;
    nxt_refSel  = refSel_ff;
    if (startDet) begin
      // RULE_17 partial byte dropped; RULE_16 low byte only in temp
      nxt_state   = sdac_pkg::ST_RECV;
      nxt_bitCnt  = 3'h0;
      nxt_full    = 1'b0;      // the start's own scl fall must not end a byte
      nxt_byteIdx = `SDAC_BYTE_ADDR;
      nxt_isSync  = 1'b0;
      nxt_sdaOeN  = 1'b1;
    end else if (stopDet) begin
      nxt_state  = sdac_pkg::ST_IDLE;
      nxt_sdaOeN = 1'b1;
      // RULE_05 stop update unless RULE_09 sync select
      if (!cmdIn_ff[`SDAC_CMD_SYNC_BIT]) begin
        nxt_code = codeOf(highIn_ff, lowIn_ff);
      end
      // RULE_12 power-down taken at stop only
      nxt_pdown  = cmdIn_ff[`SDAC_CMD_PDOWN_BIT];
      // RULE_13 reference taken at stop, even when sync select blocks the update
      nxt_refSel = cmdIn_ff[`SDAC_CMD_REF_BIT];
    end else begin
      case (state_ff)
        sdac_pkg::ST_RECV: begin
          if (sclRise) begin
            nxt_shift  = rxByte;
            nxt_bitCnt = 3'(bitCnt_ff + 3'h1);
            if (bitCnt_ff == `SDAC_LAST_BIT) begin
              nxt_full = 1'b1;
              if (byteIdx_ff == `SDAC_BYTE_ADDR) begin
                // RULE_01 own address with write bit zero
                // RULE_18 broadcast address, any last bit
                nxt_isSync = (rxByte[7:1] == `SDAC_SYNC_ADDR);
                nxt_accept = (addrMatch(rxByte[7:1], addrSelS) & ~rxByte[0]) |
                             (rxByte[7:1] == `SDAC_SYNC_ADDR);
              end else begin
                nxt_accept = 1'b1;
              end
            end
          end else if (sclFall && full_ff) begin
            nxt_full   = 1'b0;
            // RULE_25 no match or read: stay released
            nxt_state  = accept_ff ? sdac_pkg::ST_ACK : sdac_pkg::ST_SKIP;
            // RULE_23 pull low for the ninth clock
            nxt_sdaOeN = ~accept_ff;
            nxt_accept = 1'b0;
          end
        end
        sdac_pkg::ST_ACK: begin
          if (sclRise) begin
            case (byteIdx_ff)
              `SDAC_BYTE_ADDR: begin
                if (isSync_ff) begin
                  if (!shift_ff[0]) begin
                    // RULE_20 clear on ack; RULE_26 everything to zero
                    nxt_cmdIn  = `SDAC_CMD_RESET;
                    nxt_lowTmp = `SDAC_DATA_RESET;
                    nxt_lowIn  = `SDAC_DATA_RESET;
                    nxt_highIn = `SDAC_DATA_RESET;
                    nxt_code   = `SDAC_CODE_RESET;
                    nxt_pdown  = 1'b0;
                    nxt_refSel = 1'b0;
                  end else if (cmdIn_ff[`SDAC_CMD_SYNC_BIT]) begin
                    // RULE_19 update needs sync select; RULE_10 at ack rise
                    nxt_code = codeOf(highIn_ff, lowIn_ff);
                  end
                end
              end
              // RULE_02 command stored; RULE_15 data untouched
              `SDAC_BYTE_CMD:  nxt_cmdIn  = shift_ff;
              // RULE_03 low byte held until the word completes
              `SDAC_BYTE_LOW:  nxt_lowTmp = shift_ff;
              // RULE_04 both data bytes committed together
              `SDAC_BYTE_HIGH: begin
                nxt_lowIn  = lowTmp_ff;
                nxt_highIn = shift_ff;
              end
              default: nxt_cmdIn = cmdIn_ff;
            endcase
          end else if (sclFall) begin
            // ack released as the ninth clock ends
            nxt_sdaOeN  = 1'b1;
            nxt_byteIdx = 2'(byteIdx_ff + 2'h1);
            nxt_state   = (isSync_ff || byteIdx_ff == `SDAC_BYTE_HIGH) ?
                          sdac_pkg::ST_SKIP : sdac_pkg::ST_RECV;
          end
        end
        // idle and skip wait for the next start or stop
        sdac_pkg::ST_IDLE: nxt_sdaOeN = 1'b1;
        sdac_pkg::ST_SKIP: nxt_sdaOeN = 1'b1;
        default: begin
          nxt_state  = sdac_pkg::ST_IDLE;
          nxt_sdaOeN = 1'b1;
        end
      endcase
    end
  end

  // RULE_14 all control bits power up zero
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      state_ff    <= sdac_pkg::ST_IDLE;
      bitCnt_ff   <= 3'h0;
      shift_ff    <= 8'h00;
      full_ff     <= 1'b0;
      byteIdx_ff  <= `SDAC_BYTE_ADDR;
      isSync_ff   <= 1'b0;
      accept_ff   <= 1'b0;
      sdaOeN_ff   <= 1'b1;
      cmdIn_ff    <= `SDAC_CMD_RESET;
      lowTmp_ff   <= `SDAC_DATA_RESET;
      lowIn_ff    <= `SDAC_DATA_RESET;
      highIn_ff   <= `SDAC_DATA_RESET;
      code_ff     <= `SDAC_CODE_RESET;
      pdown_ff    <= 1'b0;
      refSel_ff   <= 1'b0;
      sdaDrive_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      bitCnt_ff   <= nxt_bitCnt;
      shift_ff    <= nxt_shift;
      full_ff     <= nxt_full;
      byteIdx_ff  <= nxt_byteIdx;
      isSync_ff   <= nxt_isSync;
      accept_ff   <= nxt_accept;
      sdaOeN_ff   <= nxt_sdaOeN;
      cmdIn_ff    <= nxt_cmdIn;
      lowTmp_ff   <= nxt_lowTmp;
      lowIn_ff    <= nxt_lowIn;
      highIn_ff   <= nxt_highIn;
      code_ff     <= nxt_code;
      pdown_ff    <= nxt_pdown;
      refSel_ff   <= nxt_refSel;
      sdaDrive_ff <= 1'b0;     // open drain: only ever pulls low
    end
  end

  // outputs straight from flops; RULE_11 power-down keeps the code
  assign sdaOut            = sdaDrive_ff;
  assign sdaOutEnN         = sdaOeN_ff;
  assign converterCode     = code_ff;
  assign powerDownSelect   = pdown_ff;
  assign internalRefSelect = refSel_ff;
  assign syncUpdateSelect  = cmdIn_ff[`SDAC_CMD_SYNC_BIT];

endmodule : sdac_write_port

// [sdac_write_port_asserts.sv]
/*
  pin-level checker of the converter write port.
  assumes it is bound onto sdac_write_port; pins show 3-4 cycles late.
*/
`timescale 1ns/1ps
module sdac_write_port_asserts (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       sclIn,
  input wire logic       sdaIn,
  input wire logic [2:0] addrSelPin,
  input wire logic       sdaOut,
  input wire logic       sdaOutEnN,
  input wire logic [9:0] converterCode,
  input wire logic       powerDownSelect,
  input wire logic       internalRefSelect,
  input wire logic       syncUpdateSelect
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // open drain: only the enable may move
  a_sda_out_low: assert property (sdaOut == 1'b0)
    else $error("sda data driven high");
  // ack covers a whole ninth clock, then ends
  a_ack_span: assert property ($fell(sdaOutEnN) |-> !sdaOutEnN [*6] ##[1:6] sdaOutEnN)
    else $error("ack length wrong");
  // enable only moves behind a low clock, never while clocking data
  a_ack_edge: assert property ($changed(sdaOutEnN) |-> !$past(sclIn, 3))
    else $error("ack edge outside scl low");
  a_sync_commit: assert property ($changed(syncUpdateSelect)
    |-> $past(sclIn, 3) && !$past(sdaIn, 3))
    else $error("sync select moved off an acked rise");
  // stop-time update blocked by sync select
  a_code_stop: assert property ($changed(converterCode) && $past(sdaIn, 3)
    |-> $past(sclIn, 3) && !$past(syncUpdateSelect))
    else $error("code moved at stop with sync set");
  // ack-time update needs sync select, or is a clear
  a_code_ack: assert property ($changed(converterCode) && !$past(sdaIn, 3)
    |-> $past(sclIn, 3) && ($past(syncUpdateSelect) || converterCode == 10'h000))
    else $error("code moved at ack without cause");
  a_pd_at_stop: assert property ($changed({powerDownSelect, internalRefSelect})
    |-> $past(sclIn, 3) && ($past(sdaIn, 3) || !(powerDownSelect | internalRefSelect)))
    else $error("power-down or ref moved off stop");
  a_reset_vals: assert property ($rose(rst_n) |-> sdaOutEnN && converterCode == 10'h000
    && !powerDownSelect && !internalRefSelect && !syncUpdateSelect)
    else $error("outputs not at power-on values");
endmodule : sdac_write_port_asserts

bind sdac_write_port sdac_write_port_asserts u_chk (.clk_sys, .rst_n, .sclIn, .sdaIn,
  .addrSelPin, .sdaOut, .sdaOutEnN, .converterCode, .powerDownSelect,
  .internalRefSelect, .syncUpdateSelect);

// [tb_sdac_write_port.sv]
/*
  self-checking bench of the converter write port: random transaction mix.
  assumes the master model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module tb_sdac_write_port;
  logic        clk_sys, rst_n, sclIn, sdaIn, sdaDrv;
  logic [2:0]  addrSelPin;
  logic        sdaOut, sdaOutEnN, powerDownSelect, internalRefSelect, syncUpdateSelect;
  logic [9:0]  converterCode, inC, outC;
  logic [7:0]  cmdR;
  logic        pdE, refE;
  logic [3:0]  ackSeen;
  logic [16:0] noteQ[$];
  int          fails, tests_run, seed;
  event        chk;
  // pull-up wins unless someone pulls low
  assign sdaIn = sdaDrv & (sdaOutEnN | sdaOut);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  sdac_bus_master m (.clk_sys, .sdaLine(sdaIn), .sclOut(sclIn), .sdaDrv);
  sdac_write_port DUT (.clk_sys, .rst_n, .sclIn, .sdaIn, .addrSelPin, .sdaOut, .sdaOutEnN,
    .converterCode, .powerDownSelect, .internalRefSelect, .syncUpdateSelect);
  task automatic check(input string nm, input logic [16:0] seen, input logic [16:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic final_report();
    if (fails == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // note = {acks, sync, ref, pd, code}
  task automatic note(input logic [3:0] e, input logic [3:0] a);
    ackSeen = a;
    noteQ.push_back({e, cmdR[0], refE, pdE, outC});
    ->chk;
  endtask : note
  // oldest note against what the pins show now
  always @(chk) begin : watch
    logic [16:0] n;
    n = noteQ.pop_front();
    check("ack", 17'(ackSeen), 17'(n[16:13]));
    check("code", 17'(converterCode), 17'(n[9:0]));
    check("pdref", 17'({internalRefSelect, powerDownSelect}), 17'(n[11:10]));
    check("sync", 17'(syncUpdateSelect), 17'(n[12]));
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    fails++;
    final_report();
  end
  // kinds: 0 word, 1 send byte, 2 foreign addr, 3 read, 4 cut data,
  // 5 cut command, 6 broadcast update, 7 broadcast clear
  initial begin
    logic [7:0] c, l, h;
    logic [3:0] a, e;
    int k;
    rst_n = 1'b0;
    addrSelPin = 3'h0;
    seed = 67465;
    {cmdR, inC, outC, pdE, refE} = '0;
    ackSeen = 4'h0;
    m.wt(2);
    rst_n = 1'b1;
    m.wt(6);
    note(4'h0, 4'h0);
    repeat (48) begin
      k = int'({$random(seed)} % 8);
      {c, l, h} = 24'($random(seed));
      addrSelPin = 3'($random(seed));
      m.wt(6);
      a = 4'h0;
      m.start_cond();
      // pins give the low address bits
      case (k)
        2: m.byte_out({4'h5, addrSelPin, 1'b0}, 8, a[0]);
        3: m.byte_out({4'h4, addrSelPin, 1'b1}, 8, a[0]);
        6, 7: m.byte_out({7'h7e, k == 6}, 8, a[0]);
        default: m.byte_out({4'h4, addrSelPin, 1'b0}, 8, a[0]);
      endcase
      if (k < 6) m.byte_out(c, (k == 5) ? 4 : 8, a[1]);
      if (k == 0 || k == 4) m.byte_out(l, 8, a[2]);
      if (k == 0) m.byte_out(h, 8, a[3]);
      // repeated start chains a send byte before the one stop
      if (k < 2 && l[0]) begin
        m.start_cond();
        m.byte_out({4'h4, addrSelPin, 1'b0}, 8, a[0]);
        m.byte_out(c, 8, a[1]);
      end
      e = {k == 0, k == 0 || k == 4, k < 2 || k == 4, k != 2 && k != 3};
      if (k < 2 || k == 4) cmdR = c;
      if (k == 0) inC = {h[1:0], l};
      // broadcast update only with sync set
      if (k == 6 && cmdR[0]) outC = inC;
      if (k == 7) {cmdR, inC, outC, pdE, refE} = '0;
      if (k > 5) note(e, a);
      m.stop_cond();
      if (!cmdR[0]) outC = inC;
      pdE = cmdR[1];
      refE = cmdR[2];
      note(e, a);
    end
    m.wt(4);
    final_report();
  end
endmodule : tb_sdac_write_port
